// File: design/mcb_params.svh
`ifndef MCB_PARAMS_SVH
`define MCB_PARAMS_SVH
// machine cycle is eight clock slots
`define MCB_SLOT_LAST      3'h7
`define MCB_SLOT_TPA       3'h1
`define MCB_SLOT_ADDR_LO   3'h3
`define MCB_SLOT_TPB       3'h6
`define MCB_SLOT_WR_ON     3'h4
`define MCB_SLOT_WR_OFF    3'h6
// ram select window, in slots (clock 31 .. clock 71)
`define MCB_SLOT_RAM_ON    3'h3
`define MCB_SLOT_RAM_LATE  3'h7
// interrupt entry values, reset program selector, toggle count
`define MCB_IRQ_XSEL       4'h2
`define MCB_IRQ_PSEL       4'h1
`define MCB_DMA_PSEL       4'h0
`define MCB_CNT_ONE        8'h01
`endif

// File: design/mcb_pkg.sv
package mcb_pkg;
   // machine cycle state type, encoded as the two state lines
   typedef enum logic [1:0] {MCB_FETCH, MCB_EXEC, MCB_DMA, MCB_IRQ} mcb_state_e;
   // control mode from clear and wait
   typedef enum logic [1:0] {MCB_RESET, MCB_PAUSE, MCB_RUN} mcb_mode_e;
endpackage

// File: design/mcb_slot_timer.sv
`timescale 1ns/1ps
`default_nettype none
`include "mcb_params.svh"
module mcb_slot_timer
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       hold,
   output logic [2:0]      slot_r,
   output logic            cycle_end
);
   // eight slots per machine cycle; hold freezes the count
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         slot_r <= 3'h0;
      else if (!hold)
         slot_r <= slot_r + 3'h1;
   end

   assign cycle_end = !hold && (slot_r == `MCB_SLOT_LAST);
endmodule
`default_nettype wire

// File: design/mcb_bus_core.sv
// Functional notes
// - io lines low except during io instruction
// - io direction bit sets read level
// - sample flags at fetch cycle end
// - sample dma requests at second pulse
// - sample interrupt in execute, dma only
// - interrupt saves selectors, sets 2/1, clears enable
// - interrupt acknowledge takes one machine cycle
// - dma uses register zero, then increments
// - priority dma in, dma out, interrupt
// - state lines encode fetch/exec/dma/interrupt
// - first then second timing pulse each cycle
// - high byte first, low half clock later; low byte here follows two clocks after first pulse ends
// - write pulse after address stable
// - read level low in memory reads
// - flag set/reset between the two pulses
// - toggle mode inverts flag at count 01
// - toggle mode cancelled by load, reset, branch
// - eight clocks per machine cycle
// - clear and wait select reset, pause, run
// - ram select window clock 31 to 71
// - saved context: data selector high nibble
// - pause enters only at a timing pulse
`timescale 1ns/1ps
`default_nettype none
`include "mcb_params.svh"
module mcb_bus_core
   import mcb_pkg::*;
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       clear_n,
   input  wire logic       wait_n,
   input  wire logic [15:0] cycle_addr,
   input  wire logic       cycle_is_read,
   input  wire logic       cycle_is_write,
   input  wire logic       instr_done,
   input  wire logic       io_instr,
   input  wire logic [3:0] instr_low_digit,
   input  wire logic       set_flag_instr,
   input  wire logic       reset_flag_instr,
   input  wire logic       toggle_enable_instr,
   input  wire logic       load_counter_instr,
   input  wire logic       counter_stopped,
   input  wire logic       branch_counter_irq_instr,
   input  wire logic       counter_irq_latch,
   input  wire logic       counter_dec,
   input  wire logic [7:0] counter_value,
   input  wire logic [3:0] data_sel_in,
   input  wire logic [3:0] prog_sel_in,
   input  wire logic [3:0] external_flag_inputs,
   input  wire logic       dma_in_req,
   input  wire logic       dma_out_req,
   input  wire logic       irq_req,
   input  wire logic       ram_select_n,
   output logic            timing_pulse_first,
   output logic            timing_pulse_second,
   output logic            state_line_high,
   output logic            state_line_low,
   output logic [7:0]      mux_address_lines,
   output logic            read_level_n,
   output logic            write_strobe_n,
   output logic [2:0]      io_command_lines,
   output logic            out_flag,
   output logic [3:0]      flags_sampled,
   output logic [7:0]      saved_context,
   output logic [3:0]      data_sel,
   output logic [3:0]      prog_sel,
   output logic            master_irq_enable,
   output logic [15:0]     dma_pointer,
   output logic            ram_drive,
   output logic            mode_run,
   output logic            mode_pause
);
   mcb_state_e  state_r, state_nxt;
   mcb_mode_e   mode;
   logic [2:0]  slot_r;
   logic        cycle_end, hold, paused_r;
   logic        dma_in_r, dma_out_r, irq_r;
   logic        toggle_r, ram_sel_r;
   logic        tpa_rise, tpb_rise, at_tpb;

   // clear low holds reset; both low is illegal and treated as reset
   always_comb
   begin
      if (!clear_n)
         mode = MCB_RESET;
      else if (!wait_n)
         mode = MCB_PAUSE;
      else
         mode = MCB_RUN;
   end

   function automatic logic slot_is(input logic [2:0] s, input logic [2:0] want);
      slot_is = (s == want);
   endfunction

   // edges that raise a pulse, and the slot in which tpb stands
   assign tpa_rise = slot_is(3'(slot_r + 3'h1), `MCB_SLOT_TPA);
   assign tpb_rise = slot_is(3'(slot_r + 3'h1), `MCB_SLOT_TPB);
   assign at_tpb   = slot_is(slot_r, `MCB_SLOT_TPB);

   // pause latches on the rising edge of a pulse, released at once by run
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         paused_r <= 1'b0;
      else if (mode != MCB_PAUSE)
         paused_r <= 1'b0;
      else if (tpa_rise || tpb_rise)
         paused_r <= 1'b1;
   end

   // gated by mode, so a stale pause bit never outlives the pause by a cycle
   assign hold       = (paused_r && mode == MCB_PAUSE) || (mode == MCB_RESET);
   assign mode_run   = (mode == MCB_RUN);
   assign mode_pause = paused_r && (mode == MCB_PAUSE);

   mcb_slot_timer u_slot
   (
      .mclk      (mclk),
      .rst       (rst),
      .hold      (hold),
      .slot_r    (slot_r),
      .cycle_end (cycle_end)
   );

   // request sampling at second pulse; interrupt not in dma-free irq cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         dma_in_r  <= 1'b0;
         dma_out_r <= 1'b0;
         irq_r     <= 1'b0;
      end
      else if (at_tpb && !hold)
      begin
         if (state_r != MCB_FETCH)
         begin
            dma_in_r  <= dma_in_req;
            dma_out_r <= dma_out_req;
         end
         else
         begin
            dma_in_r  <= 1'b0;
            dma_out_r <= 1'b0;
         end
         // level only, so the source must keep asserting
         irq_r <= irq_req && (state_r == MCB_EXEC || state_r == MCB_DMA);
      end
   end

   // next cycle type; dma first, then interrupt, after instruction ends
   always_comb
   begin
      state_nxt = MCB_FETCH;
      if ((state_r == MCB_FETCH) || (state_r == MCB_EXEC && !instr_done))
         state_nxt = (state_r == MCB_FETCH) ? MCB_EXEC : MCB_EXEC;
      if (state_r != MCB_FETCH && (state_r != MCB_EXEC || instr_done))
      begin
         if (dma_in_r || dma_out_r)
            state_nxt = MCB_DMA;
         else if (irq_r && master_irq_enable)
            state_nxt = MCB_IRQ;
         else
            state_nxt = MCB_FETCH;
      end
   end

   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         state_r <= MCB_FETCH;
      else if (mode == MCB_RESET)
         state_r <= MCB_FETCH;
      else if (cycle_end)
         state_r <= state_nxt;
   end

   // state lines straight from the cycle type, stable across the pulse
   assign state_line_high = state_r[1];
   assign state_line_low  = state_r[0];

   // pulses one clock wide at fixed slots
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         timing_pulse_first  <= 1'b0;
         timing_pulse_second <= 1'b0;
      end
      else
      begin
         timing_pulse_first  <= !hold && tpa_rise;
         timing_pulse_second <= !hold && tpb_rise;
      end
   end

   // address mux: high byte through the first pulse, low byte after
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         mux_address_lines <= 8'h00;
      else if (slot_r < `MCB_SLOT_ADDR_LO)
         mux_address_lines <= (state_r == MCB_DMA) ? dma_pointer[15:8] : cycle_addr[15:8];
      else
         mux_address_lines <= (state_r == MCB_DMA) ? dma_pointer[7:0] : cycle_addr[7:0];
   end

   // read level and write pulse; io uses direction bit for read level
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         read_level_n   <= 1'b1;
         write_strobe_n <= 1'b1;
      end
      else
      begin
         if (state_r == MCB_EXEC && io_instr)
            read_level_n <= instr_low_digit[3];
         else if (state_r == MCB_DMA)
            read_level_n <= dma_in_r; // dma-in writes memory
         else
            read_level_n <= !cycle_is_read && state_r != MCB_FETCH;
         // write only after the low byte has settled
         write_strobe_n <= !(((state_r == MCB_DMA && dma_in_r) ||
                              (state_r == MCB_EXEC && cycle_is_write)) &&
                             slot_r >= `MCB_SLOT_WR_ON && slot_r < `MCB_SLOT_WR_OFF);
      end
   end

   // io command lines carry low digit only while io instruction runs
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         io_command_lines <= 3'h0;
      else if (state_r == MCB_EXEC && io_instr)
         io_command_lines <= instr_low_digit[2:0];
      else
         io_command_lines <= 3'h0;
   end

   // flags caught at fetch cycle end
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         flags_sampled <= 4'h0;
      else if (cycle_end && state_r == MCB_FETCH)
         flags_sampled <= external_flag_inputs;
   end

   // interrupt entry updates selectors at the acknowledge cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         saved_context     <= 8'h00;
         data_sel          <= 4'h0;
         prog_sel          <= `MCB_DMA_PSEL;
         master_irq_enable <= 1'b1;
      end
      else if (mode == MCB_RESET)
         master_irq_enable <= 1'b1;
      else if (cycle_end && state_r == MCB_IRQ)
      begin
         saved_context     <= {data_sel, prog_sel};
         data_sel          <= `MCB_IRQ_XSEL;
         prog_sel          <= `MCB_IRQ_PSEL;
         master_irq_enable <= 1'b0;
      end
      else if (cycle_end && instr_done && state_r == MCB_EXEC)
      begin
         data_sel <= data_sel_in;
         prog_sel <= prog_sel_in;
      end
   end

   // dma pointer is register zero; bumped after each transfer
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         dma_pointer <= 16'h0000;
      else if (cycle_end && state_r == MCB_DMA)
         dma_pointer <= dma_pointer + 16'h0001;
   end

   // output flag: instructions act between pulses, toggle on underflow
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         out_flag <= 1'b0;
      else if (state_r == MCB_EXEC && slot_is(slot_r, `MCB_SLOT_ADDR_LO) && set_flag_instr)
         out_flag <= 1'b1;
      else if (state_r == MCB_EXEC && slot_is(slot_r, `MCB_SLOT_ADDR_LO) && reset_flag_instr)
         out_flag <= 1'b0;
      else if (toggle_r && counter_dec && counter_value == `MCB_CNT_ONE)
         out_flag <= !out_flag;
   end

   // toggle mode; cancel wins over a same-cycle enable
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         toggle_r <= 1'b0;
      else if (mode == MCB_RESET ||
               (load_counter_instr && counter_stopped) ||
               (branch_counter_irq_instr && counter_irq_latch))
         toggle_r <= 1'b0;
      else if (toggle_enable_instr)
         toggle_r <= 1'b1;
   end

   // ram select must be seen before the late slot; drops after it
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         ram_sel_r <= 1'b0;
      else if (slot_is(slot_r, `MCB_SLOT_RAM_LATE) || hold)
         ram_sel_r <= 1'b0;
      else if (!ram_select_n && !(read_level_n && write_strobe_n))
         ram_sel_r <= 1'b1;
   end

   // base decode is external, so no address check here
   assign ram_drive = ram_sel_r && !ram_select_n && (slot_r >= `MCB_SLOT_RAM_ON) && !read_level_n;
endmodule
`default_nettype wire

// File: verif/mcb_far_side.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_far_side
#(
   parameter logic [7:0] RAM_HI = 8'h40
)
(
   input  wire logic       mclk,
   input  wire logic       rst,
   input  wire logic       timing_pulse_first,
   input  wire logic       timing_pulse_second,
   input  wire logic       state_line_high,
   input  wire logic       state_line_low,
   input  wire logic [7:0] mux_address_lines,
   input  wire logic       irq_arm,
   input  wire logic       ram_en,
   output logic            irq_req,
   output logic            ram_select_n,
   output logic [15:0]     addr_seen
);
   logic       tpa_d_r;
   logic [7:0] hi_r;
   // address latch: high byte as the first pulse ends, low byte at the second
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
      begin
         tpa_d_r <= 1'b0;
         hi_r <= 8'h00;
         addr_seen <= 16'h0000;
      end
      else
      begin
         tpa_d_r <= timing_pulse_first;
         if (tpa_d_r && !timing_pulse_first)
            hi_r <= mux_address_lines;
         if (timing_pulse_second)
            addr_seen <= {hi_r, mux_address_lines};
      end
   end
   // request is not latched inside, so hold it until the acknowledge cycle
   always_ff @(posedge mclk or posedge rst)
   begin
      if (rst)
         irq_req <= 1'b0;
      else if (state_line_high && state_line_low)
         irq_req <= 1'b0;
      else if (irq_arm)
         irq_req <= 1'b1;
   end
   // base decode outside; held from one high byte latch to the next, in the following cycle
   assign ram_select_n = !(ram_en && hi_r == RAM_HI);
endmodule
`default_nettype wire

// File: verif/mcb_checker_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module mcb_checker
(
   input wire logic        mclk,
   input wire logic        rst,
   input wire logic        clear_n,
   input wire logic        wait_n,
   input wire logic [15:0] cycle_addr,
   input wire logic        io_instr,
   input wire logic [3:0]  instr_low_digit,
   input wire logic        timing_pulse_first,
   input wire logic        timing_pulse_second,
   input wire logic        state_line_high,
   input wire logic        state_line_low,
   input wire logic [7:0]  mux_address_lines,
   input wire logic        write_strobe_n,
   input wire logic [2:0]  io_command_lines,
   input wire logic [3:0]  data_sel,
   input wire logic [3:0]  prog_sel,
   input wire logic        master_irq_enable,
   input wire logic        mode_run,
   input wire logic        mode_pause
);
   logic [1:0] st;
   // slot timing freezes in reset and, from the next pulse, in pause, so timing checks rest outside run
   assign st = {state_line_high, state_line_low};
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || !mode_run);
   sequence s_tpb_late;
      !timing_pulse_second[*4] ##1 timing_pulse_second;
   endsequence
   sequence s_cycle;
      !timing_pulse_first[*7] ##1 timing_pulse_first;
   endsequence
   sequence s_wr_low;
      !write_strobe_n ##1 write_strobe_n;
   endsequence
   pulse_order_a: assert property ($rose(timing_pulse_first) |=> s_tpb_late)
      else $error("second pulse misplaced");
   cycle_len_a: assert property ($rose(timing_pulse_first) |=> s_cycle)
      else $error("cycle not eight clocks");
   state_hold_a: assert property ($rose(timing_pulse_first) |=> $stable(st)[*5])
      else $error("state lines moved");
   io_code_a: assert property (
      (io_instr && $stable(instr_low_digit))[*8] ##0 (st == 2'h1 && timing_pulse_second)
      |-> io_command_lines == instr_low_digit[2:0])
      else $error("io lines wrong");
   addr_low_a: assert property (
      $fell(timing_pulse_first) && !state_line_high
      |-> ##[1:2] mux_address_lines == cycle_addr[7:0])
      else $error("low address late");
   write_addr_a: assert property ($fell(write_strobe_n) |-> $stable(mux_address_lines) ##1 s_wr_low)
      else $error("write before address");
   irq_entry_a: assert property (
      $rose(st == 2'h3) |-> ##[0:8] (data_sel == 4'h2 && prog_sel == 4'h1 && !master_irq_enable))
      else $error("interrupt entry wrong");
   mode_decode_a: assert property (
      disable iff (rst) mode_run == (clear_n && wait_n) && (!mode_pause || clear_n && !wait_n))
      else $error("mode decode wrong");
endmodule
bind mcb_bus_core mcb_checker u_mcb_checker (.*);
`default_nettype wire

// File: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   int n_errors = 0;
   int n_compared = 0;
   // stimulus, all valued at time zero
   logic mclk = 1'b0, rst = 1'b1, clear_n = 1'b1, wait_n = 1'b1, io_instr = 1'b0;
   logic set_flag_instr = 1'b0, reset_flag_instr = 1'b0, toggle_enable_instr = 1'b0;
   logic load_counter_instr = 1'b0, counter_stopped = 1'b0, counter_dec = 1'b0;
   logic dma_in_req = 1'b0, dma_out_req = 1'b0, irq_arm = 1'b0, ram_en = 1'b0;
   logic branch_counter_irq_instr = 1'b0, counter_irq_latch = 1'b0;
   logic [15:0] cycle_addr = 16'h0000;
   logic [7:0] counter_value = 8'h00;
   logic [3:0] instr_low_digit = 4'h0, external_flag_inputs = 4'h0;
   logic [3:0] data_sel_in = 4'h7, prog_sel_in = 4'h3;
   // observed
   logic timing_pulse_first, timing_pulse_second, state_line_high, state_line_low;
   logic read_level_n, write_strobe_n, out_flag, master_irq_enable, ram_drive;
   logic mode_run, mode_pause, irq_req, ram_select_n;
   logic [7:0] mux_address_lines, saved_context;
   logic [2:0] io_command_lines;
   logic [3:0] flags_sampled, data_sel, prog_sel;
   logic [15:0] dma_pointer, addr_seen;
   logic [1:0] st;
   int k;
   assign st = {state_line_high, state_line_low};
   always #2.5 mclk = ~mclk;
   // instruction decode side is played by the bench, one-cycle instructions
   mcb_bus_core u_mcb_bus_core (.*, .cycle_is_read(1'b0), .cycle_is_write(1'b0),
      .instr_done(1'b1));
   mcb_far_side u_mcb_far_side (.*);
   task automatic end_sim();
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1)
      begin
         n_errors++;
         $display("Error %0t %s", $time, m);
      end
   endtask
   // inputs move 1 ns after the edge, never on it
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic nt();
      int i;
      i = 0;
      do
      begin
         step(1);
         i++;
      end
      while (timing_pulse_first !== 1'b1 && i < 20);
   endtask
   task automatic wst(input logic [1:0] s);
      nt();
      repeat (4) if (st !== s) nt();
      chk(st === s, "state wait");
   endtask
   task automatic dec(input logic [7:0] v);
      counter_value = v;
      counter_dec = 1'b1;
      step(1);
      counter_dec = 1'b0;
      step(2);
   endtask
   task automatic t_io();
      io_instr = 1'b1;
      instr_low_digit = 4'hD;
      wst(2'h1);
      step(4);
      chk(io_command_lines === 3'h5 && read_level_n === 1'b1, "io input");
      instr_low_digit = 4'h6;
      wst(2'h1);
      step(4);
      chk(io_command_lines === 3'h6 && read_level_n === 1'b0, "io output");
      io_instr = 1'b0;
      wst(2'h1);
      wst(2'h1);
      chk(io_command_lines === 3'h0, "io idle");
   endtask
   task automatic t_flags();
      external_flag_inputs = 4'hA;
      wst(2'h1);
      external_flag_inputs = 4'h5;
      step(5);
      chk(flags_sampled === 4'hA, "flags held");
      wst(2'h1);
      chk(flags_sampled === 4'h5, "flags new");
   endtask
   task automatic t_q();
      for (int v = 1; v >= 0; v--)
      begin
         wst(2'h0);
         set_flag_instr = v[0];
         reset_flag_instr = !v[0];
         wst(2'h1);
         chk(out_flag === !v[0], "flag early");
         step(3);
         chk(out_flag === v[0], "flag late");
      end
      reset_flag_instr = 1'b0;
   endtask
   task automatic t_tog();
      toggle_enable_instr = 1'b1;
      wst(2'h0);
      toggle_enable_instr = 1'b0;
      dec(8'h05);
      chk(out_flag === 1'b0, "no toggle");
      dec(8'h01);
      chk(out_flag === 1'b1, "toggle");
      load_counter_instr = 1'b1;
      counter_stopped = 1'b1;
      wst(2'h0);
      load_counter_instr = 1'b0;
      dec(8'h01);
      chk(out_flag === 1'b1, "toggle off");
      toggle_enable_instr = 1'b1;
      wst(2'h0);
      toggle_enable_instr = 1'b0;
      branch_counter_irq_instr = 1'b1;
      counter_irq_latch = 1'b1;
      step(1);
      branch_counter_irq_instr = 1'b0;
      counter_irq_latch = 1'b0;
      dec(8'h01);
      chk(out_flag === 1'b1, "branch cancel");
   endtask
   task automatic t_req();
      irq_arm = 1'b1;
      dma_in_req = 1'b1;
      dma_out_req = 1'b1;
      step(1);
      irq_arm = 1'b0;
      wst(2'h2);
      dma_in_req = 1'b0;
      nt();
      chk(st === 2'h2 && dma_pointer === 16'h0001, "dma out");
      dma_out_req = 1'b0;
      step(3);
      chk(read_level_n === 1'b0, "dma read");
      nt();
      chk(st === 2'h3 && dma_pointer === 16'h0002, "irq last");
      nt();
      chk(st === 2'h0 && saved_context === 8'h73 && data_sel === 4'h2, "irq entry");
      chk(prog_sel === 4'h1 && master_irq_enable === 1'b0, "irq sel");
      irq_arm = 1'b1;
      step(1);
      irq_arm = 1'b0;
      repeat (4)
      begin
         nt();
         chk(st !== 2'h3, "irq masked");
      end
   endtask
   task automatic t_pause();
      nt();
      wait_n = 1'b0;
      step(1);
      chk(mode_pause === 1'b0, "pause early");
      step(8);
      chk(mode_pause === 1'b1 && mode_run === 1'b0, "pause");
      k = 0;
      repeat (24)
      begin
         step(1);
         k += int'(timing_pulse_first === 1'b1);
      end
      chk(k === 0, "pulses in pause");
      wait_n = 1'b1;
      clear_n = 1'b0;
      step(3);
      chk(mode_run === 1'b0 && mode_pause === 1'b0 && st === 2'h0, "reset mode");
      clear_n = 1'b1;
   endtask
   task automatic t_ram(input logic [15:0] a, input logic sel);
      ram_en = 1'b1;
      nt();
      step(4);
      cycle_addr = a;
      wst(2'h0);
      k = 0;
      repeat (8)
      begin
         step(1);
         k += int'(ram_drive === 1'b1);
      end
      chk((k > 0) === sel, "ram drive");
      nt();
      chk(addr_seen === a, "address latch");
   endtask
   initial
   begin
      repeat (2) @(posedge mclk);
      #1;
      rst = 1'b0;
      t_io();
      t_flags();
      t_q();
      t_tog();
      t_req();
      t_pause();
      t_ram(16'h4012, 1'b1);
      t_ram(16'h1234, 1'b0);
      end_sim();
   end
   // hang guard, far beyond the few dozen machine cycles used
   initial
   begin
      #100000;
      n_errors++;
      $display("Error %0t timeout", $time);
      end_sim();
   end
endmodule
`default_nettype wire
